// ### design/dbg_sync2.v
`timescale 1ns/1ps
`include "dbg_port_defs.vh"

// Two-flop synchroniser; the first stage feeds only the second.
module dbg_sync2 (
    input wire i_sys_clk,
    input wire i_nrst,
    input wire i_async,
    output reg o_sync
);
    reg meta_q;

    // Two stages clear metastability before any logic reads the level.
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// ### design/dbg_trace_port.v
`timescale 1ns/1ps
`include "dbg_port_defs.vh"
// Operation
// - Serial clock level accepted after two equal samples.
// - Serial clock rise samples input, updates output.
// - Serial output comes from a register.
// - Breakpoint halts after instruction, status shows 0xF.
// - Data nibble shows breakpoint status unless capturing.
// - Write-trace instruction captures its operand unless FIFO full.
// - Both nibbles refresh every processor cycle.
// - Status nibble tracks pipeline, not bus transfer.
// - All debug signals unidirectional, rising-edge timed.
// - Eight-bit trace output: status and data nibbles.
// - Indirect branch targets shown nibble per cycle.
// - Two-entry 32-bit FIFO buffers captured values.
// - Entries unloaded low nibble first.
// - Stall core while both entries full, one cycle late.
// - Flash security blocks serial debug traffic.
// - Serial channel: clock, input, output, full duplex.
// - Halt mode keeps core halted during commands.
// - Serial commands may run while core executes.
// - Codes 0x8-0xB precede data by one cycle.
// - Code 0x1 first cycle, 0x0 later cycles.
// - Hold 0xC exceptions and 0xD emulator entry.
// - Hold 0xE while stopped until interrupt.
module dbg_trace_port #(
    parameter ENTRY_W = `ENTRY_BITS,
    parameter DEPTH = `FIFO_DEPTH
) (
    input wire i_sys_clk,
    input wire i_nrst,
    input wire i_debug_serial_clock,
    input wire i_debug_serial_in,
    input wire i_breakpoint_request,
    input wire i_flash_secure,
    input wire i_capture_enable,
    input wire i_branch_target_enable,
    input wire [2:0] i_core_event,
    input wire i_core_cycle_more,
    input wire i_core_insn_done,
    input wire i_interrupt,
    input wire i_wdata_valid,
    input wire [1:0] i_wdata_size,
    input wire [ENTRY_W-1:0] i_wdata,
    input wire i_capture_valid,
    input wire [1:0] i_capture_size,
    input wire [ENTRY_W-1:0] i_capture_data,
    input wire i_branch_indirect,
    input wire [ENTRY_W-1:0] i_branch_target,
    input wire [3:0] i_breakpoint_request_status,
    input wire i_halt_release,
    output reg o_debug_serial_out,
    output reg [3:0] o_processor_status_nibble,
    output reg [3:0] o_trace_data_nibble,
    output reg o_processor_clock_out,
    output reg o_core_stall,
    output reg o_core_halted,
    output reg o_serial_word_valid,
    output reg [ENTRY_W-1:0] o_serial_word
);
    // Nibble count of an entry from its byte size code (0 = one byte).
    function [3:0] nibbles_of;
        input [1:0] size;
        begin
            nibbles_of = {1'b0, size, 1'b1} + 4'h1;
        end
    endfunction

    wire sclk_s;
    wire sdi_s;
    reg sclk_a_q;
    reg sclk_ok_q;
    reg sclk_prev_q;
    reg [ENTRY_W-1:0] shin_q;
    reg [ENTRY_W-1:0] shout_q;
    reg [5:0] bitcnt_q;
    reg [ENTRY_W-1:0] mem_q [0:DEPTH-1];
    reg [1:0] msize_q [0:DEPTH-1];
    reg [1:0] count_q;
    reg rd_q;
    reg wr_q;
    reg [3:0] nib_left_q;
    reg [ENTRY_W-1:0] shdata_q;
    reg active_q;
    reg announced_q;
    reg hold_q;
    reg [3:0] hold_code_q;
    reg breakpoint_request_pend_q;
    reg halted_q;
    reg push;
    reg [ENTRY_W-1:0] push_data;
    reg [1:0] push_size;
    reg pop;
    reg [3:0] pst_d;
    reg mark_now;
    wire sclk_rise;

    // Serial clock and input cross into the processor clock domain.
    dbg_sync2 u_sync_clk (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async(i_debug_serial_clock),
        .o_sync(sclk_s)
    );
    dbg_sync2 u_sync_din (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async(i_debug_serial_in),
        .o_sync(sdi_s)
    );

    // A level counts only after two consecutive equal samples.
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sclk_a_q <= 1'b0;
            sclk_ok_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_a_q <= sclk_s;
            if (sclk_s == sclk_a_q)
                sclk_ok_q <= sclk_s;
            sclk_prev_q <= sclk_ok_q;
        end
    end
    assign sclk_rise = sclk_ok_q & ~sclk_prev_q;

    // Full-duplex shifter; secure flash freezes it so nothing leaks out.
    // It runs regardless of whether the core executes or is halted.
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            shin_q <= {ENTRY_W{1'b0}};
            shout_q <= {ENTRY_W{1'b0}};
            bitcnt_q <= 6'h00;
            o_debug_serial_out <= `DSO_RESET;
            o_serial_word_valid <= 1'b0;
            o_serial_word <= {ENTRY_W{1'b0}};
        end else begin
            o_serial_word_valid <= 1'b0;
            if (i_flash_secure) begin
                bitcnt_q <= 6'h00;
                o_debug_serial_out <= `DSO_RESET;
            end else if (sclk_rise) begin
                shin_q <= {shin_q[ENTRY_W-2:0], sdi_s};
                o_debug_serial_out <= shout_q[ENTRY_W-1];
                shout_q <= {shout_q[ENTRY_W-2:0], 1'b0};
                if (bitcnt_q == `SER_BITS - 6'h01) begin
                    bitcnt_q <= 6'h00;
                    o_serial_word_valid <= 1'b1;
                    o_serial_word <= {shin_q[ENTRY_W-2:0], sdi_s};
                    shout_q <= {shin_q[ENTRY_W-2:0], sdi_s};
                end else begin
                    bitcnt_q <= bitcnt_q + 6'h01;
                end
            end
        end
    end

    // Pick the capture source; the write-trace operand always wins.
    always @* begin
        push = 1'b0;
        push_data = i_capture_data;
        push_size = i_capture_size;
        if (i_wdata_valid) begin
            push = 1'b1;
            push_data = i_wdata;
            push_size = i_wdata_size;
        end else if (i_branch_indirect && i_branch_target_enable) begin
            push = 1'b1;
            push_data = i_branch_target;
            push_size = 2'h3;
        end else if (i_capture_valid && i_capture_enable) begin
            push = 1'b1;
        end
    end

    // Two-entry FIFO; a push is dropped while full, even in the first full
    // cycle, before the registered stall has reached the core.
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_q <= 2'h0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            mem_q[0] <= {ENTRY_W{1'b0}};
            mem_q[1] <= {ENTRY_W{1'b0}};
            msize_q[0] <= 2'h0;
            msize_q[1] <= 2'h0;
        end else begin
            if (push && count_q != DEPTH) begin
                mem_q[wr_q] <= push_data;
                msize_q[wr_q] <= push_size;
                wr_q <= ~wr_q;
            end
            if (pop)
                rd_q <= ~rd_q;
            if ((push && count_q != DEPTH) && !pop)
                count_q <= count_q + 2'h1;
            else if (pop && !(push && count_q != DEPTH))
                count_q <= count_q - 2'h1;
        end
    end

    // Start unloading the head when idle and already announced.
    always @* begin
        pop = 1'b0;
        if (!active_q && count_q != 2'h0 && announced_q)
            pop = 1'b1;
    end

    // Status nibble from pipeline events; announce code leads the data.
    always @* begin
        pst_d = `PST_CONTINUE;
        mark_now = 1'b0;
        if (halted_q)
            pst_d = `PST_HALTED;
        else if (hold_q && !(hold_code_q == `PST_STOPPED && i_interrupt))
            pst_d = hold_code_q;
        else if (!active_q && count_q != 2'h0 && !announced_q) begin
            pst_d = `PST_XFER1 + {2'b00, msize_q[rd_q]};
            mark_now = 1'b1;
        end else begin
            case (i_core_event)
                `EV_BEGIN: pst_d = i_wdata_valid ? `PST_MARK : `PST_BEGIN;
                `EV_BRANCH: pst_d = `PST_BRANCH;
                `EV_EXCEPT: pst_d = `PST_EXCEPT;
                `EV_EMUL: pst_d = `PST_EMUL;
                `EV_STOP: pst_d = `PST_STOPPED;
                `EV_USER: pst_d = `PST_USER;
                `EV_RTE: pst_d = `PST_RTE;
                default: pst_d = `PST_CONTINUE;
            endcase
        end
    end

    // Outputs refresh every cycle; the clock output toggles for sampling.
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_processor_status_nibble <= `PST_CONTINUE;
            o_trace_data_nibble <= 4'h0;
            o_processor_clock_out <= 1'b0;
            o_core_stall <= 1'b0;
            o_core_halted <= 1'b0;
            active_q <= 1'b0;
            announced_q <= 1'b0;
            nib_left_q <= 4'h0;
            shdata_q <= {ENTRY_W{1'b0}};
            hold_q <= 1'b0;
            hold_code_q <= `PST_CONTINUE;
            breakpoint_request_pend_q <= 1'b0;
            halted_q <= 1'b0;
        end else begin
            o_processor_clock_out <= ~o_processor_clock_out;
            o_processor_status_nibble <= pst_d;
            o_core_stall <= (count_q == DEPTH);
            o_core_halted <= halted_q;
            // The low nibble leaves on the pop edge, so data follows the
            // marker by exactly one cycle.
            if (pop) begin
                o_trace_data_nibble <= mem_q[rd_q][3:0];
                shdata_q <= {4'h0, mem_q[rd_q][ENTRY_W-1:4]};
                nib_left_q <= nibbles_of(msize_q[rd_q]) - 4'h1;
                active_q <= 1'b1;
                announced_q <= 1'b0;
            end else if (active_q) begin
                o_trace_data_nibble <= shdata_q[3:0];
                shdata_q <= {4'h0, shdata_q[ENTRY_W-1:4]};
                nib_left_q <= nib_left_q - 4'h1;
                if (nib_left_q == 4'h1)
                    active_q <= 1'b0;
            end else begin
                // Only a marker that really went out arms the unload.
                if (mark_now)
                    announced_q <= 1'b1;
                o_trace_data_nibble <= i_breakpoint_request_status;
            end
            // Multi-cycle modes latch their code until they end.
            if (!hold_q && (pst_d == `PST_EXCEPT || pst_d == `PST_EMUL ||
                    pst_d == `PST_STOPPED) && !halted_q) begin
                hold_q <= 1'b1;
                hold_code_q <= pst_d;
            end else if (hold_q && ((hold_code_q == `PST_STOPPED) ?
                    i_interrupt : i_core_insn_done)) begin
                hold_q <= 1'b0;
            end
            // Breakpoint waits for the current instruction to finish.
            if (i_breakpoint_request)
                breakpoint_request_pend_q <= 1'b1;
            if ((breakpoint_request_pend_q || i_breakpoint_request) && i_core_insn_done
                    && !i_core_cycle_more) begin
                halted_q <= 1'b1;
                breakpoint_request_pend_q <= 1'b0;
            end else if (i_halt_release && !i_breakpoint_request) begin
                halted_q <= 1'b0;
            end
        end
    end
endmodule

// ### shared/dbg_port_defs.vh
`ifndef DBG_PORT_DEFS_VH
`define DBG_PORT_DEFS_VH

// Processor status codes shown on the status nibble.
`define PST_CONTINUE 4'h0
`define PST_BEGIN 4'h1
`define PST_USER 4'h3
`define PST_MARK 4'h4
`define PST_BRANCH 4'h5
`define PST_RTE 4'h7
`define PST_XFER1 4'h8
`define PST_XFER4 4'hB
`define PST_EXCEPT 4'hC
`define PST_EMUL 4'hD
`define PST_STOPPED 4'hE
`define PST_HALTED 4'hF

// Core event codes presented on the core status input.
`define EV_NONE 3'h0
`define EV_BEGIN 3'h1
`define EV_BRANCH 3'h2
`define EV_EXCEPT 3'h3
`define EV_EMUL 3'h4
`define EV_STOP 3'h5
`define EV_USER 3'h6
`define EV_RTE 3'h7

// Serial shift length and trace entry geometry.
`define SER_BITS 6'h20
`define ENTRY_BITS 32
`define FIFO_DEPTH 2

// Reset value of the serial output register.
`define DSO_RESET 1'b0

`endif

// ### testbench/dbg_host_model.sv
`timescale 1ns/1ps
// Emulator end of the serial channel: one word MSB first per request.
module dbg_host_model (
    input wire i_go,
    input wire [31:0] i_word,
    input wire i_dso,
    output reg o_debug_serial_clock,
    output reg o_dsi,
    output reg [31:0] o_rx
);
    integer k;
    initial begin
        o_debug_serial_clock = 1'b0;
        o_dsi = 1'b0;
        o_rx = 32'h0;
    end
    // A 320 ns period stays below a fifth of the processor rate; the
    // reply is read late in the low phase, after the synchroniser delay.
    always @(posedge i_go) begin
        for (k = 31; k >= 0; k = k - 1) begin
            #140 o_rx = {o_rx[30:0], i_dso};
            o_dsi = i_word[k];
            #20 o_debug_serial_clock = 1'b1;
            #160 o_debug_serial_clock = 1'b0;
        end
        #140 o_rx = {o_rx[30:0], i_dso};
        o_dsi = ~o_dsi;
    end
endmodule

// ### testbench/dbg_trace_port_monitor.sv
`timescale 1ns/1ps
`include "dbg_port_defs.vh"
// Ties trace codes, stall, halt and serial blocking to their causes.
module dbg_trace_port_monitor #(
    parameter ENTRY_W = 32
) (
    input wire i_sys_clk,
    input wire i_nrst,
    input wire i_breakpoint_request,
    input wire i_flash_secure,
    input wire [2:0] i_core_event,
    input wire i_core_insn_done,
    input wire i_interrupt,
    input wire i_wdata_valid,
    input wire [1:0] i_wdata_size,
    input wire [ENTRY_W-1:0] i_wdata,
    input wire i_capture_valid,
    input wire i_branch_indirect,
    input wire o_debug_serial_out,
    input wire [3:0] o_processor_status_nibble,
    input wire [3:0] o_trace_data_nibble,
    input wire o_processor_clock_out,
    input wire o_core_stall,
    input wire o_core_halted,
    input wire o_serial_word_valid
);
    reg [4:0] quiet_q;
    reg [1:0] age_q;
    wire push = i_wdata_valid | i_capture_valid | i_branch_indirect;
    wire idle = (quiet_q == 5'h1F) && !o_core_halted;
    // Code checks wait until the trace queue has surely drained.
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            quiet_q <= 5'h00;
            age_q <= 2'h0;
        end else begin
            quiet_q <= push ? 5'h00 : quiet_q + {4'h0, !(&quiet_q)};
            age_q <= age_q + {1'b0, !(&age_q)};
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    AST_PCLK: assert property (age_q == 2'h3 |->
        o_processor_clock_out != $past(o_processor_clock_out))
        else $error("clock out did not toggle");
    AST_SECURE: assert property (i_flash_secure [*3] |->
        !o_serial_word_valid && !o_debug_serial_out)
        else $error("serial traffic while secured");
    AST_HALT: assert property (i_breakpoint_request &&
        i_core_insn_done |-> ##[1:3] (o_core_halted &&
        o_processor_status_nibble == `PST_HALTED))
        else $error("breakpoint did not halt");
    AST_MARK: assert property (i_wdata_valid && idle |=> ##1
        o_processor_status_nibble == {2'b10, $past(i_wdata_size, 2)})
        else $error("wrong length marker");
    AST_LSB: assert property (i_wdata_valid && idle |=> ##2
        o_trace_data_nibble == $past(i_wdata[3:0], 3))
        else $error("first nibble is not the low one");
    AST_EXCEPT: assert property (i_core_event == `EV_EXCEPT &&
        idle ##1 (!i_core_insn_done) [*2] |=>
        o_processor_status_nibble == `PST_EXCEPT)
        else $error("exception code not held");
    AST_STOP: assert property (i_core_event == `EV_STOP &&
        idle ##1 (!i_interrupt) [*3] |=>
        o_processor_status_nibble == `PST_STOPPED)
        else $error("stopped code not held");
    AST_STALL: assert property (o_core_stall |->
        ##[1:24] !o_core_stall)
        else $error("stall not released");
endmodule

bind dbg_trace_port dbg_trace_port_monitor #(.ENTRY_W(ENTRY_W))
    dbg_trace_port_monitor_i (.i_sys_clk, .i_nrst, .i_breakpoint_request,
    .i_flash_secure, .i_core_event, .i_core_insn_done, .i_interrupt,
    .i_wdata_valid, .i_wdata_size, .i_wdata, .i_capture_valid,
    .i_branch_indirect, .o_debug_serial_out, .o_processor_status_nibble,
    .o_trace_data_nibble, .o_processor_clock_out, .o_core_stall,
    .o_core_halted, .o_serial_word_valid);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`include "dbg_port_defs.vh"
`define CHK(nm, e, g) begin \
    n_tests = n_tests + 1; \
    if ((g) !== (e)) begin \
        fails = fails + 1; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
end
// Bench for the trace and serial debug port.
module tb_top;
    reg clk, nrst, breakpoint_request, sec, cap_en, br_en, more, done, intr;
    reg wv, cv, bi, hrel, go, v;
    reg [2:0] ev;
    reg [1:0] wsz, csz;
    reg [3:0] bs;
    reg [31:0] wd, cd, bt, hw, got;
    wire debug_serial_clock, dsi, debug_serial_out, pco, stall, halted, swv;
    wire [3:0] processor_status_nibble, dd;
    wire [31:0] sw, rx;
    integer fails, n_tests;
    // Processor clock at 25 MHz.
    always #20 clk = ~clk;
    dbg_trace_port dbg_trace_port_i (.i_sys_clk(clk), .i_nrst(nrst),
        .i_debug_serial_clock(debug_serial_clock), .i_debug_serial_in(dsi),
        .i_breakpoint_request(breakpoint_request), .i_flash_secure(sec),
        .i_capture_enable(cap_en), .i_branch_target_enable(br_en),
        .i_core_event(ev), .i_core_cycle_more(more), .i_core_insn_done(done),
        .i_interrupt(intr), .i_wdata_valid(wv), .i_wdata_size(wsz),
        .i_wdata(wd), .i_capture_valid(cv), .i_capture_size(csz),
        .i_capture_data(cd), .i_branch_indirect(bi), .i_branch_target(bt),
        .i_breakpoint_request_status(bs), .i_halt_release(hrel),
        .o_debug_serial_out(debug_serial_out), .o_processor_status_nibble(processor_status_nibble),
        .o_trace_data_nibble(dd), .o_processor_clock_out(pco),
        .o_core_stall(stall), .o_core_halted(halted),
        .o_serial_word_valid(swv), .o_serial_word(sw));
    dbg_host_model dbg_host_model_i (.i_go(go), .i_word(hw), .i_dso(debug_serial_out),
        .o_debug_serial_clock(debug_serial_clock), .o_dsi(dsi), .o_rx(rx));
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // One serial word; a received word is kept when its pulse shows.
    task send(input [31:0] w, output f);
        integer k;
        begin
            f = 1'b0;
            hw = w;
            go = 1'b1;
            for (k = 0; k < 300; k = k + 1) begin
                @(negedge clk);
                go = 1'b0;
                if (swv === 1'b1) begin
                    f = 1'b1;
                    got = sw;
                end
            end
        end
    endtask
    // Pushes z+1 bytes from one source, then reads marker and nibbles.
    task push_chk(input integer s, input [1:0] z, input [31:0] d);
        integer k;
        begin
            {wd, cd, bt, wsz, csz, ev} = {d, d, d, z, z, `EV_BEGIN};
            {wv, bi, cv} = {s == 0, s == 1, s == 2};
            @(negedge clk);
            {wv, bi, cv, ev} = 6'h00;
            `CHK("begin", (s == 0) ? `PST_MARK : `PST_BEGIN, processor_status_nibble)
            @(negedge clk);
            `CHK("marker", {2'b10, z}, processor_status_nibble)
            for (k = 0; k < 2 * z + 2; k = k + 1) begin
                @(negedge clk);
                `CHK("nibble", d[4*k +: 4], dd)
            end
        end
    endtask
    // A status code shown for one event cycle.
    task t_code(input [2:0] e, input [3:0] c);
        begin
            ev = e;
            @(negedge clk);
            ev = `EV_NONE;
            `CHK("code", c, processor_status_nibble)
        end
    endtask
    // Multi-cycle codes stay until done or interrupt ends them.
    task t_hold(input [2:0] e, input [3:0] c, input s);
        begin
            t_code(e, c);
            repeat (3) @(negedge clk);
            `CHK("held", c, processor_status_nibble)
            {intr, done} = {s, !s};
            @(negedge clk);
            {intr, done} = 2'h0;
            repeat (2) @(negedge clk);
            `CHK("left", `PST_CONTINUE, processor_status_nibble)
        end
    endtask
    task t_trace;
        integer k;
        begin
            // A long quiet spell lets the idle-gated checks see a push.
            bs = 4'h6;
            repeat (32) @(negedge clk);
            `CHK("breakpoint_request status", 4'h6, dd)
            v = pco;
            @(negedge clk);
            `CHK("clock out", ~v, pco)
            push_chk(0, 2'h0, 32'h0000005A);
            push_chk(0, 2'h3, 32'h87654321);
            br_en = 1'b1;
            push_chk(1, 2'h3, 32'h1234ABCD);
            cap_en = 1'b1;
            push_chk(2, 2'h1, 32'h0000D2C3);
            {wv, v} = 2'h2;
            repeat (3) @(negedge clk);
            wv = 1'b0;
            for (k = 0; k < 40; k = k + 1) begin
                if (stall === 1'b1)
                    v = 1'b1;
                @(negedge clk);
            end
            `CHK("stall seen", 2'h2, {v, stall})
            $display("test trace done");
        end
    endtask
    task t_core;
        begin
            more = 1'b1;
            t_code(`EV_BEGIN, `PST_BEGIN);
            @(negedge clk);
            `CHK("continue", `PST_CONTINUE, processor_status_nibble)
            more = 1'b0;
            t_code(`EV_USER, `PST_USER);
            t_code(`EV_BRANCH, `PST_BRANCH);
            t_code(`EV_RTE, `PST_RTE);
            t_hold(`EV_EXCEPT, `PST_EXCEPT, 1'b0);
            t_hold(`EV_EMUL, `PST_EMUL, 1'b0);
            t_hold(`EV_STOP, `PST_STOPPED, 1'b1);
            $display("test core done");
        end
    endtask
    task t_serial;
        begin
            send(32'hC3A50F96, v);
            `CHK("word", 33'h1C3A50F96, {v, got})
            send(32'h5A5A1234, v);
            `CHK("echo", 32'hC3A50F96, rx)
            sec = 1'b1;
            send(32'h0F0F0F0F, v);
            `CHK("secure", 2'h0, {v, debug_serial_out})
            sec = 1'b0;
            {breakpoint_request, done} = 2'h3;
            @(negedge clk);
            done = 1'b0;
            repeat (3) @(negedge clk);
            `CHK("halt", {1'b1, `PST_HALTED}, {halted, processor_status_nibble})
            breakpoint_request = 1'b0;
            send(32'h00FF00FF, v);
            `CHK("halt word", 33'h100FF00FF, {halted, got})
            hrel = 1'b1;
            @(negedge clk);
            hrel = 1'b0;
            repeat (2) @(negedge clk);
            `CHK("released", 1'b0, halted)
            $display("test serial done");
        end
    endtask
    initial begin
        {clk, nrst, breakpoint_request, sec, cap_en, br_en, more, done, intr} = 9'h000;
        {wv, cv, bi, hrel, go, v, ev, wsz, csz, bs} = 17'h00000;
        {wd, cd, bt, hw, got} = 160'h0;
        fails = 0;
        n_tests = 0;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        t_trace;
        t_core;
        t_serial;
        conclude;
    end
    // The run needs about 1350 cycles; over seven times that ends a hang.
    initial begin
        #400000;
        fails = fails + 1;
        conclude;
    end
endmodule
